// >>> rtl/swcs_clk_mon.sv
// Clock monitor: flags an oscillator whose edges stop or come too slowly
`timescale 1ns/1ps
module swcs_clk_mon #(
    parameter int TIMEOUT_CYC = swcs_pkg::CM_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Monitor control and observed oscillator
    input wire logic enable,
    input wire logic osc_in,
    // Verdict
    output logic freq_err
);
    import swcs_pkg::*;

    localparam logic [CM_W-1:0] LIMIT = CM_W'(TIMEOUT_CYC);

    generate
        if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << CM_W)) begin : g_bad
            $error("swcs_clk_mon: TIMEOUT_CYC out of range");
        end
    endgenerate

    logic osc_d_r, osc_d_nxt;
    logic [CM_W-1:0] gap_r, gap_nxt;
    logic err_r, err_nxt;

    always_comb begin
        osc_d_nxt = osc_in;
        gap_nxt = gap_r;
        err_nxt = err_r;
        if (osc_in && !osc_d_r) begin
            // A rising edge inside the limit means the rate has recovered
            if (gap_r < LIMIT) begin
                err_nxt = 1'b0;
            end
            gap_nxt = '0;
        end else if (gap_r < LIMIT) begin
            gap_nxt = gap_r + CM_W'(1);
        end else begin
            err_nxt = 1'b1;
        end
        if (!enable) begin
            err_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            osc_d_r <= 1'b0;
            gap_r <= '0;
            err_r <= 1'b0;
        end else begin
            osc_d_r <= osc_d_nxt;
            gap_r <= gap_nxt;
            err_r <= err_nxt;
        end
    end

    assign freq_err = err_r;
endmodule : swcs_clk_mon

// >>> rtl/swcs_pkg.sv
// Constants and types shared by the service-window clock supervisor
package swcs_pkg;
    // Service word layout
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int KEY_HI = 5;
    localparam int KEY_LO = 1;
    localparam int CM_BIT = 0;
    localparam logic [4:0] SVC_KEY = 5'h0C;
    localparam logic [4:0] KEY_READ = 5'h00;
    localparam logic [1:0] SEL_RESET = 2'h3;
    localparam logic CM_RESET = 1'b1;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int IC_PERIOD_NS = 1000;
    localparam int IC_DIV = (IC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 6;
    localparam int LOWER_IC = 2048;
    localparam int UPPER_BASE_IC = 8192;
    localparam int WCNT_W = 17;
    localparam int STRETCH_IC = 16;
    localparam int STR_W = 5;
    // Clock monitor: any gap between rising oscillator edges above this is a fault
    localparam int CM_TIMEOUT_US = 1000;
    localparam int CM_TIMEOUT_CYC = CM_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int CM_W = 24;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DRIVE = 4'b0010,
        ST_STRETCH = 4'b0100,
        ST_RELEASE = 4'b1000
    } swcs_state_e;
endpackage : swcs_pkg

// >>> rtl/swcs_top.sv
// Service-window supervisor with clock monitor and open-drain fault pin
`timescale 1ns/1ps
module swcs_top #(
    parameter int LOWER_CYC = swcs_pkg::LOWER_IC,
    parameter int UPPER_BASE_CYC = swcs_pkg::UPPER_BASE_IC,
    parameter int CM_TIMEOUT = swcs_pkg::CM_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Service word access
    input wire logic svc_wr,
    input wire logic [7:0] svc_wdata,
    output logic [7:0] svc_rdata,
    // Low-power modes
    input wire logic halt_mode,
    input wire logic idle_mode,
    input wire logic idle_exit,
    // Oscillator seen by the clock monitor
    input wire logic oscillator_input,
    // Open-drain fault pin
    input wire logic fault_pin_i,
    output logic fault_pin_o,
    output logic fault_pin_oe,
    // Status
    output logic window_fault,
    output logic clock_fault
);
    import swcs_pkg::*;

    generate
        if (LOWER_CYC < 1 || UPPER_BASE_CYC <= LOWER_CYC || (UPPER_BASE_CYC << 3) >= (1 << WCNT_W))
        begin : g_bad
            $error("swcs_top: window bounds out of range");
        end
    endgenerate

    function automatic logic [WCNT_W-1:0] upper_limit(input logic [1:0] sel);
        upper_limit = WCNT_W'(UPPER_BASE_CYC) << sel;
    endfunction : upper_limit

    ////////////////////////////////////////////////////////////////////////////
    // Instruction-cycle enable
    logic [DIV_W-1:0] div_r, div_nxt;
    logic ic_en_r, ic_en_nxt;

    always_comb begin
        if (div_r == DIV_W'(IC_DIV - 1)) begin
            div_nxt = '0;
            ic_en_nxt = 1'b1;
        end else begin
            div_nxt = div_r + DIV_W'(1);
            ic_en_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_r <= '0;
            ic_en_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            ic_en_r <= ic_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock monitor
    logic cm_en_r, cm_en_nxt;
    logic cm_err;

    swcs_clk_mon #(
        .TIMEOUT_CYC(CM_TIMEOUT)
    ) u_clk_mon (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(cm_en_r),
        .osc_in(oscillator_input),
        .freq_err(cm_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Service window and fault pin
    logic [1:0] sel_r, sel_nxt;
    logic first_done_r, first_done_nxt;
    logic [WCNT_W-1:0] wcnt_r, wcnt_nxt;
    logic wd_err_r, wd_err_nxt;
    swcs_state_e st_r, st_nxt;
    logic [STR_W-1:0] str_r, str_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic stopped;
    logic key_ok;
    logic restart;
    logic svc_err;

    always_comb begin
        sel_nxt = sel_r;
        cm_en_nxt = cm_en_r;
        first_done_nxt = first_done_r;
        wcnt_nxt = wcnt_r;
        wd_err_nxt = 1'b0;
        st_nxt = st_r;
        str_nxt = str_r;
        restart = 1'b0;
        svc_err = 1'b0;
        stopped = halt_mode || idle_mode;
        key_ok = (svc_wdata[KEY_HI:KEY_LO] == SVC_KEY);
        // A write is a service only in ST_IDLE, once the released pin has been seen high again
        if (svc_wr && st_r == ST_IDLE) begin
            if (!first_done_r) begin
                if (key_ok) begin
                    sel_nxt = svc_wdata[SEL_HI:SEL_LO];
                    cm_en_nxt = svc_wdata[CM_BIT];
                    first_done_nxt = 1'b1;
                    restart = 1'b1;
                end else begin
                    svc_err = 1'b1;
                end
            end else if (svc_wdata != {sel_r, SVC_KEY, cm_en_r}) begin
                svc_err = 1'b1;
            end else if (wcnt_r < WCNT_W'(LOWER_CYC)) begin
                svc_err = 1'b1;
            end else begin
                restart = 1'b1;
            end
        end
        if (idle_exit) begin
            restart = 1'b1;
        end
        if (restart) begin
            wcnt_nxt = '0;
        end else if (ic_en_r && !stopped && st_r == ST_IDLE) begin
            if (wcnt_r >= upper_limit(sel_r)) begin
                wd_err_nxt = 1'b1;
            end else begin
                wcnt_nxt = wcnt_r + WCNT_W'(1);
            end
        end
        if (svc_err) begin
            wd_err_nxt = 1'b1;
        end
        case (st_r)
            ST_IDLE: begin
                if (wd_err_r || cm_err) begin
                    st_nxt = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                // Stretch only starts once the pin is really low
                if (!fault_pin_i && !cm_err) begin
                    st_nxt = ST_STRETCH;
                    str_nxt = '0;
                end
            end
            ST_STRETCH: begin
                if (cm_err) begin
                    st_nxt = ST_DRIVE;
                end else if (ic_en_r) begin
                    if (str_r == STR_W'(STRETCH_IC)) begin
                        st_nxt = ST_RELEASE;
                    end else begin
                        str_nxt = str_r + STR_W'(1);
                    end
                end
            end
            ST_RELEASE: begin
                if (cm_err) begin
                    st_nxt = ST_DRIVE;
                end else if (fault_pin_i) begin
                    st_nxt = ST_IDLE;
                    wcnt_nxt = '0;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        oe_nxt = (st_nxt == ST_DRIVE) || (st_nxt == ST_STRETCH);
        rd_nxt = {sel_r, KEY_READ, cm_en_r};
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_r <= SEL_RESET;
            cm_en_r <= CM_RESET;
            first_done_r <= 1'b0;
            wcnt_r <= '0;
            wd_err_r <= 1'b0;
            st_r <= ST_IDLE;
            str_r <= '0;
            oe_r <= 1'b0;
            rd_r <= '0;
        end else begin
            sel_r <= sel_nxt;
            cm_en_r <= cm_en_nxt;
            first_done_r <= first_done_nxt;
            wcnt_r <= wcnt_nxt;
            wd_err_r <= wd_err_nxt;
            st_r <= st_nxt;
            str_r <= str_nxt;
            oe_r <= oe_nxt;
            rd_r <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags
    logic wf_r, wf_nxt;
    logic cf_r, cf_nxt;

    always_comb begin
        wf_nxt = wf_r;
        if (wd_err_r) begin
            wf_nxt = 1'b1;
        end else if (st_r == ST_IDLE) begin
            wf_nxt = 1'b0;
        end
        cf_nxt = cm_err;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wf_r <= 1'b0;
            cf_r <= 1'b0;
        end else begin
            wf_r <= wf_nxt;
            cf_r <= cf_nxt;
        end
    end

    assign svc_rdata = rd_r;
    assign fault_pin_o = 1'b0;
    assign fault_pin_oe = oe_r;
    assign window_fault = wf_r;
    assign clock_fault = cf_r;
endmodule : swcs_top

// >>> verification/swcs_chk.sv
// Port checker for the supervisor
`timescale 1ns/1ps
module swcs_chk #(
    parameter int CM_TIMEOUT = swcs_pkg::CM_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Service word
    input wire logic svc_wr,
    input wire logic [7:0] svc_wdata,
    input wire logic [7:0] svc_rdata,
    // Oscillator, pin, status
    input wire logic oscillator_input,
    input wire logic fault_pin_i,
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe,
    input wire logic clock_fault
);
    import swcs_pkg::*;
    logic [11:0] lo_r, lo_nxt;
    logic [23:0] gap_r, gap_nxt;
    logic osc_r, fst_r, fst_nxt, tk;
    // A write counts only while idle and the pin is back high
    assign tk = svc_wr && !fault_pin_oe && fault_pin_i;
    always_comb begin
        lo_nxt = (fault_pin_oe && !fault_pin_i && !clock_fault) ? lo_r + 12'h001 : 12'h000;
        gap_nxt = (oscillator_input && !osc_r) ? 24'h000000 : gap_r + 24'h000001;
        fst_nxt = fst_r || tk;
    end
    always_ff @(posedge mclk) begin
        lo_r <= rst_n ? lo_nxt : 12'h000;
        gap_r <= rst_n ? gap_nxt : 24'h000000;
        fst_r <= rst_n && fst_nxt;
        osc_r <= oscillator_input;
    end
    ////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_bad; tk && svc_wdata[KEY_HI:KEY_LO] != SVC_KEY; endsequence
    sequence s_first; !fst_r && tk && svc_wdata[KEY_HI:KEY_LO] == SVC_KEY; endsequence
    property p_rst; disable iff (1'b0) !rst_n |=> !fault_pin_oe && !clock_fault; endproperty
    a_rst: assert property (p_rst) else $error("fault active after reset");
    // The pull-up needs a few cycles after release, so the pin level itself is not judged here
    property p_od; fault_pin_o == 1'b0 && (fault_pin_oe || !clock_fault); endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_key; s_bad |-> ##2 fault_pin_oe; endproperty
    a_key: assert property (p_key) else $error("bad key not flagged");
    property p_cfg; s_first |-> ##2 svc_rdata == {$past(svc_wdata[7:6], 2), 5'h00, $past(svc_wdata[0], 2)}; endproperty
    a_cfg: assert property (p_cfg) else $error("first write not loaded");
    property p_rd; svc_rdata[KEY_HI:KEY_LO] == KEY_READ; endproperty
    a_rd: assert property (p_rd) else $error("key readable");
    property p_ign; fault_pin_oe && svc_wr |-> ##2 $stable(svc_rdata); endproperty
    a_ign: assert property (p_ign) else $error("write taken while active");
    property p_rel; $fell(fault_pin_oe) |-> lo_r >= 12'h280 && lo_r <= 12'h500; endproperty
    a_rel: assert property (p_rel) else $error("hold time off");
    property p_cm; gap_r > CM_TIMEOUT + 8 && svc_rdata[0] |-> clock_fault && fault_pin_oe; endproperty
    a_cm: assert property (p_cm) else $error("stopped clock not flagged");
    property p_cmoff; clock_fault |-> svc_rdata[0]; endproperty
    a_cmoff: assert property (p_cmoff) else $error("monitor off but erred");
endmodule : swcs_chk
bind swcs_top swcs_chk #(.CM_TIMEOUT(CM_TIMEOUT)) i_swcs_chk (.mclk, .rst_n, .svc_wr, .svc_wdata, .svc_rdata,
    .oscillator_input, .fault_pin_i, .fault_pin_o, .fault_pin_oe, .clock_fault);

// >>> verification/swcs_pin_model.sv
// Outside system logic: pull-up resistor on the open-drain fault pin
`timescale 1ns/1ps
module swcs_pin_model (
    // Clock
    input wire logic mclk,
    // Device side of the pin
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe,
    // Wire level
    output logic pin_level
);
    logic [1:0] rise_r = 2'h0;
    // Resistor pull-up is slow, so the line is not high at the instant of release
    always @(posedge mclk) begin
        if (fault_pin_oe) begin
            rise_r <= 2'h0;
        end else if (rise_r != 2'h3) begin
            rise_r <= rise_r + 2'h1;
        end
    end
    assign pin_level = fault_pin_oe ? fault_pin_o : (rise_r == 2'h3);
endmodule : swcs_pin_model

// >>> verification/tb_swcs_top.sv
// Self-checking bench for the supervisor
`timescale 1ns/1ps
module tb_swcs_top;
    import swcs_pkg::*;
    logic mclk, rst_n, svc_wr, halt_mode, idle_mode, idle_exit, oscillator_input, osc_run, fault_pin_i;
    logic fault_pin_o, fault_pin_oe, window_fault, clock_fault;
    logic [7:0] svc_wdata, svc_rdata;
    logic [1:0] div;
    int n_errors = 0;
    int checked = 0;
    swcs_top #(.LOWER_CYC(8), .UPPER_BASE_CYC(32), .CM_TIMEOUT(200)) i_swcs_top (.mclk, .rst_n, .svc_wr,
        .svc_wdata, .svc_rdata, .halt_mode, .idle_mode, .idle_exit, .oscillator_input, .fault_pin_i,
        .fault_pin_o, .fault_pin_oe, .window_fault, .clock_fault);
    swcs_pin_model i_swcs_pin_model (.mclk, .fault_pin_o, .fault_pin_oe, .pin_level(fault_pin_i));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        div <= div + 2'h1;
        if (osc_run && div == 2'h0) oscillator_input <= ~oscillator_input;
    end
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic ic(input int n);
        repeat (n * 40) @(posedge mclk);
    endtask : ic
    task automatic wr(input logic [7:0] d);
        svc_wr <= 1'b1;
        svc_wdata <= d;
        @(posedge mclk);
        svc_wr <= 1'b0;
    endtask : wr
    task automatic oe_is(input logic e);
        repeat (2) @(posedge mclk);
        #1 chk("oe", {7'h00, e}, {7'h00, fault_pin_oe});
        @(posedge mclk);
    endtask : oe_is
    // Waits for release; a hold far below 16 instruction cycles is a fault
    task automatic wait_rel();
        int k;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (fault_pin_oe !== 1'b0 && k < 3000);
        chk("hold", 8'h01, {7'h00, k >= 480 && k < 3000});
        ic(1);
        chk("window_fault", 8'h00, {7'h00, window_fault});
    endtask : wait_rel
    task automatic rst();
        rst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk("rdata", 8'hC1, svc_rdata);
        @(posedge mclk);
    endtask : rst
    ////////////////////////////////////////
    task automatic t_key();
        wr(8'hC3);
        oe_is(1'b1);
        chk("window_fault", 8'h01, {7'h00, window_fault});
        wr(8'h18);
        wait_rel();
        chk("rdata kept", 8'hC1, svc_rdata);
    endtask : t_key
    task automatic t_clk();
        int k;
        wr(8'hD9);
        oe_is(1'b0);
        osc_run <= 1'b0;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (clock_fault !== 1'b1 && k < 400);
        chk("clock_fault", 8'h01, {7'h00, clock_fault});
        ic(10);
        chk("oe held", 8'h01, {7'h00, fault_pin_oe});
        osc_run <= 1'b1;
        wait_rel();
    endtask : t_clk
    task automatic t_first();
        wr(8'h18);
        oe_is(1'b0);
        chk("rdata cfg", 8'h00, svc_rdata);
        ic(2);
        wr(8'h18);
        oe_is(1'b1);
        wait_rel();
    endtask : t_first
    task automatic t_serv();
        for (int i = 0; i < 3; i++) begin
            ic(10);
            wr(8'h18);
            oe_is(1'b0);
        end
        ic(28);
        chk("oe early", 8'h00, {7'h00, fault_pin_oe});
        ic(6);
        chk("oe upper", 8'h01, {7'h00, fault_pin_oe});
        wait_rel();
    endtask : t_serv
    task automatic t_mis();
        logic [7:0] bad [3] = '{8'h19, 8'h58, 8'h1A};
        for (int i = 0; i < 3; i++) begin
            ic(10);
            wr(bad[i]);
            oe_is(1'b1);
            wait_rel();
        end
    endtask : t_mis
    task automatic t_stop();
        ic(10);
        wr(8'h18);
        halt_mode <= 1'b1;
        osc_run <= 1'b0;
        ic(40);
        chk("halt oe", 8'h00, {7'h00, fault_pin_oe});
        halt_mode <= 1'b0;
        osc_run <= 1'b1;
        // Past the lower bound here, so only the exit restart can make the next write early
        ic(10);
        idle_mode <= 1'b1;
        ic(40);
        chk("idle oe", 8'h00, {7'h00, fault_pin_oe});
        idle_mode <= 1'b0;
        idle_exit <= 1'b1;
        @(posedge mclk);
        idle_exit <= 1'b0;
        ic(2);
        wr(8'h18);
        oe_is(1'b1);
        wait_rel();
    endtask : t_stop
    // Middle window sizes: upper bound of up instruction cycles
    task automatic t_sel(input logic [7:0] d, input int up);
        rst();
        wr(d);
        oe_is(1'b0);
        chk("rdata sel", {d[7:6], 6'h00}, svc_rdata);
        ic(up - 4);
        chk("oe before upper", 8'h00, {7'h00, fault_pin_oe});
        ic(6);
        chk("oe after upper", 8'h01, {7'h00, fault_pin_oe});
        wait_rel();
    endtask : t_sel
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        {rst_n, svc_wr, halt_mode, idle_mode, idle_exit, oscillator_input} = 6'h00;
        svc_wdata = 8'h00;
        div = 2'h0;
        osc_run = 1'b1;
        rst();
        t_key();
        rst();
        t_clk();
        rst();
        t_first();
        t_serv();
        t_mis();
        t_stop();
        t_sel(8'h58, 64);
        t_sel(8'h98, 128);
        print_verdict();
    end
    initial begin
        #2000000;
        n_errors++;
        print_verdict();
    end
endmodule : tb_swcs_top
